// [logic/cees_pkg.sv]
// constants and field layout for the can event and error status block
package cees_pkg;
   localparam logic [7:0]  ADDR_FLAGS   = 8'h00;
   localparam logic [7:0]  ADDR_CODE    = 8'h04;
   localparam logic [7:0]  ADDR_ERR     = 8'h08;
   localparam logic [7:0]  ADDR_FIFO    = 8'h0C;
   localparam logic [7:0]  ADDR_CTRL    = 8'h10;
   localparam int          BIT_INVALID  = 15;
   localparam int          BIT_WAKE     = 14;
   localparam int          BIT_BUSERR   = 13;
   localparam int          BIT_SYSERR   = 12;
   localparam int          BIT_RXOVF    = 11;
   localparam int          BIT_MODE     = 3;
   localparam int          BIT_TIMER    = 2;
   localparam int          BIT_RXBUF    = 1;
   localparam int          BIT_TXBUF    = 0;
   localparam int          ENA_OFS      = 16;
   localparam logic [15:0] FLAG_IMPL    = 16'hF80F;
   localparam logic [15:0] FLAG_SW_CLR  = 16'hE80C;
   localparam logic [15:0] FLAGS_RESET  = 16'h0000;
   localparam logic [15:0] ENA_RESET    = 16'h0000;
   localparam int          CTRL_ON_BIT  = 15;
   localparam logic        CTRL_ON_RST  = 1'b0;
   localparam int          FILT_LSB     = 8;
   localparam int          TXCNT_LSB    = 8;
   localparam int          ESTATE_LSB   = 16;
   localparam logic [8:0]  WARN_LIM     = 9'h060;
   localparam logic [8:0]  PASSIVE_LIM  = 9'h080;
   localparam logic [8:0]  BUSOFF_LIM   = 9'h100;
   localparam int          NSRC         = 8;
   localparam int          SRC_BUSERR   = 0;
   localparam int          SRC_WAKE     = 1;
   localparam int          SRC_RXOVF    = 2;
   localparam int          SRC_ADDRERR  = 3;
   localparam int          SRC_BWERR    = 4;
   localparam int          SRC_TIMER    = 5;
   localparam int          SRC_MODE     = 6;
   localparam int          SRC_INVALID  = 7;
   localparam logic [6:0]  CODE_NONE    = 7'h40;
   localparam logic [6:0]  SRC_CODE [NSRC] = '{7'h41, 7'h42, 7'h43, 7'h44,
                                               7'h45, 7'h46, 7'h47, 7'h48};
   localparam logic [4:0]  FILT_RESET   = 5'h00;
endpackage : cees_pkg

// [logic/cees_stat_if.sv]
// carrier between the status top and its decoder and encoder
`timescale 1ns/1ns
interface cees_stat_if;
   logic [8:0]  tx_cnt;
   logic [7:0]  rx_cnt;
   logic [5:0]  err_state;
   logic [7:0]  src_req;
   logic [15:0] fifo_req;
   logic [6:0]  code;
   modport err_mp (input tx_cnt, rx_cnt, output err_state);
   modport enc_mp (input src_req, fifo_req, output code);
   modport top_mp (output tx_cnt, rx_cnt, src_req, fifo_req, input err_state, code);
endinterface : cees_stat_if

// [logic/cees_err_state.sv]
// error state decode from transmit and receive error counts
`timescale 1ns/1ns
module cees_err_state (
   cees_stat_if.err_mp st
);
   logic tx_warn;
   logic rx_warn;

   always_comb begin
      tx_warn = (st.tx_cnt >= cees_pkg::WARN_LIM) && (st.tx_cnt < cees_pkg::PASSIVE_LIM);
      rx_warn = ({1'b0, st.rx_cnt} >= cees_pkg::WARN_LIM)
                && ({1'b0, st.rx_cnt} < cees_pkg::PASSIVE_LIM);
      st.err_state[5] = st.tx_cnt >= cees_pkg::BUSOFF_LIM;
      st.err_state[4] = st.tx_cnt >= cees_pkg::PASSIVE_LIM;
      st.err_state[3] = {1'b0, st.rx_cnt} >= cees_pkg::PASSIVE_LIM;
      st.err_state[2] = tx_warn;
      st.err_state[1] = rx_warn;
      st.err_state[0] = tx_warn | rx_warn;
   end
endmodule : cees_err_state

// [logic/cees_code_enc.sv]
// fixed-priority encoder for the interrupt source code
`timescale 1ns/1ns
module cees_code_enc (
   cees_stat_if.enc_mp st
);
   always_comb begin
      st.code = cees_pkg::CODE_NONE;
      for (int i = 15; i >= 0; i--) begin
         if (st.fifo_req[i]) begin
            st.code = 7'(i);
         end
      end
      for (int i = cees_pkg::NSRC - 1; i >= 0; i--) begin
         if (st.src_req[i]) begin
            st.code = cees_pkg::SRC_CODE[i];
         end
      end
   end
endmodule : cees_code_enc

// [logic/cees_status_top.sv]
// event flags, interrupt code, error counts and fifo pending with apb access
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ns
module cees_status_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire logic        wake_event,
   input  wire logic        bus_error_event,
   input  wire logic        sys_addr_error,
   input  wire logic        sys_bw_error,
   input  wire logic        rx_overflow_event,
   input  wire logic        timer_overflow_event,
   input  wire logic        invalid_message_event,
   input  wire logic        rx_buffer_pending,
   input  wire logic        tx_buffer_pending,
   input  wire logic [2:0]  current_operating_mode,
   input  wire logic [2:0]  requested_operating_mode,
   input  wire logic [4:0]  matched_filter_number,
   input  wire logic [15:0] fifo_int_pending,
   input  wire logic [8:0]  tx_error_count,
   input  wire logic [7:0]  rx_error_count,
   output      logic        module_on,
   output      logic        irq_request
);
   cees_stat_if st ();

   // apb slave state
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic        pready_q;
   logic        pready_d;
   logic        pslverr_q;
   logic        pslverr_d;
   logic        wr_take;
   logic        setup;
   logic        mapped;

   // control and flag state
   logic        on_q;
   logic        on_d;
   logic [15:0] flags_q;
   logic [15:0] flags_d;
   logic [15:0] ena_q;
   logic [15:0] ena_d;
   logic        sys_bw_q;
   logic        sys_bw_d;
   logic [2:0]  mode_prev_q;
   logic [2:0]  mode_prev_d;
   logic        mode_seen_q;
   logic        mode_seen_d;
   logic [15:0] set_v;
   logic [15:0] clr_v;

   // status capture state
   logic [6:0]  code_q;
   logic [6:0]  code_d;
   logic [4:0]  filt_q;
   logic [4:0]  filt_d;
   logic [15:0] fifo_q;
   logic [15:0] fifo_d;
   logic [8:0]  txcnt_q;
   logic [8:0]  txcnt_d;
   logic [7:0]  rxcnt_q;
   logic [7:0]  rxcnt_d;
   logic [5:0]  estate_q;
   logic [5:0]  estate_d;
   logic        irq_q;
   logic        irq_d;

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == cees_pkg::ADDR_FLAGS) || (a == cees_pkg::ADDR_CODE)
                   || (a == cees_pkg::ADDR_ERR) || (a == cees_pkg::ADDR_FIFO)
                   || (a == cees_pkg::ADDR_CTRL);
   endfunction : addr_known

   cees_err_state u_err (
      .st (st.err_mp)
   );

   cees_code_enc u_enc (
      .st (st.enc_mp)
   );

   assign prdata      = prdata_q;
   assign pready      = pready_q;
   assign pslverr     = pslverr_q;
   assign module_on   = on_q;
   assign irq_request = irq_q;

   // apb: one wait-free access phase, data prepared in setup
   always_comb begin
      setup     = psel && !penable;
      mapped    = addr_known(paddr);
      wr_take   = psel && penable && pready_q && pwrite && !pslverr_q;
      pready_d  = setup;
      pslverr_d = setup && !mapped;
      prdata_d  = prdata_q;
      if (setup) begin
         prdata_d = 32'h0000_0000;
         unique case (paddr)
            cees_pkg::ADDR_FLAGS: begin
               prdata_d = {ena_q & cees_pkg::FLAG_IMPL, flags_q & cees_pkg::FLAG_IMPL};
            end
            cees_pkg::ADDR_CODE: begin
               prdata_d[cees_pkg::FILT_LSB +: 5] = filt_q;
               prdata_d[6:0]                     = code_q;
            end
            cees_pkg::ADDR_ERR: begin
               prdata_d[cees_pkg::ESTATE_LSB +: 6] = estate_q;
               prdata_d[cees_pkg::TXCNT_LSB +: 8]  = txcnt_q[7:0];
               prdata_d[7:0]                       = rxcnt_q;
            end
            cees_pkg::ADDR_FIFO: begin
               prdata_d[15:0] = fifo_q;
            end
            cees_pkg::ADDR_CTRL: begin
               prdata_d[cees_pkg::CTRL_ON_BIT] = on_q;
            end
            default: begin
               prdata_d = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // flag, enable and control next values; hardware set beats software clear
   always_comb begin
      on_d        = on_q;
      ena_d       = ena_q;
      mode_prev_d = current_operating_mode;
      mode_seen_d = 1'b1;
      sys_bw_d    = sys_bw_q;
      clr_v       = 16'h0000;
      set_v       = 16'h0000;
      set_v[cees_pkg::BIT_INVALID] = invalid_message_event;
      set_v[cees_pkg::BIT_WAKE]    = wake_event;
      set_v[cees_pkg::BIT_BUSERR]  = bus_error_event;
      set_v[cees_pkg::BIT_SYSERR]  = sys_addr_error | sys_bw_error;
      set_v[cees_pkg::BIT_RXOVF]   = rx_overflow_event;
      // reported mode reached request
      // no edge until the mode was sampled once: reset value is not a real mode
      set_v[cees_pkg::BIT_MODE]    = mode_seen_q && (current_operating_mode != mode_prev_q)
                                     && (current_operating_mode == requested_operating_mode);
      set_v[cees_pkg::BIT_TIMER]   = timer_overflow_event;
      if (wr_take && paddr == cees_pkg::ADDR_FLAGS) begin
         ena_d = pwdata[31:16] & cees_pkg::FLAG_IMPL;
         clr_v = ~pwdata[15:0] & cees_pkg::FLAG_SW_CLR;
      end
      if (wr_take && paddr == cees_pkg::ADDR_CTRL) begin
         on_d = pwdata[cees_pkg::CTRL_ON_BIT];
      end
      if (on_d && !on_q) begin
         clr_v[cees_pkg::BIT_SYSERR] = 1'b1;
      end
      flags_d = (flags_q & ~clr_v) | set_v;
      flags_d[cees_pkg::BIT_RXBUF] = rx_buffer_pending;
      flags_d[cees_pkg::BIT_TXBUF] = tx_buffer_pending;
      flags_d = flags_d & cees_pkg::FLAG_IMPL;
      // latest fault kind picks address or bandwidth code
      if (sys_bw_error) begin
         sys_bw_d = 1'b1;
      end else if (sys_addr_error) begin
         sys_bw_d = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_q        <= cees_pkg::CTRL_ON_RST;
         flags_q     <= cees_pkg::FLAGS_RESET;
         ena_q       <= cees_pkg::ENA_RESET;
         sys_bw_q    <= 1'b0;
         mode_prev_q <= 3'h0;
         mode_seen_q <= 1'b0;
      end else begin
         on_q        <= on_d;
         flags_q     <= flags_d;
         ena_q       <= ena_d;
         sys_bw_q    <= sys_bw_d;
         mode_prev_q <= mode_prev_d;
         mode_seen_q <= mode_seen_d;
      end
   end

   // requests into the encoder and error decoder
   always_comb begin
      st.src_req[cees_pkg::SRC_BUSERR]  = flags_q[cees_pkg::BIT_BUSERR]
                                          & ena_q[cees_pkg::BIT_BUSERR];
      st.src_req[cees_pkg::SRC_WAKE]    = flags_q[cees_pkg::BIT_WAKE]
                                          & ena_q[cees_pkg::BIT_WAKE];
      st.src_req[cees_pkg::SRC_RXOVF]   = flags_q[cees_pkg::BIT_RXOVF]
                                          & ena_q[cees_pkg::BIT_RXOVF];
      st.src_req[cees_pkg::SRC_ADDRERR] = flags_q[cees_pkg::BIT_SYSERR]
                                          & ena_q[cees_pkg::BIT_SYSERR] & ~sys_bw_q;
      st.src_req[cees_pkg::SRC_BWERR]   = flags_q[cees_pkg::BIT_SYSERR]
                                          & ena_q[cees_pkg::BIT_SYSERR] & sys_bw_q;
      st.src_req[cees_pkg::SRC_TIMER]   = flags_q[cees_pkg::BIT_TIMER]
                                          & ena_q[cees_pkg::BIT_TIMER];
      st.src_req[cees_pkg::SRC_MODE]    = flags_q[cees_pkg::BIT_MODE]
                                          & ena_q[cees_pkg::BIT_MODE];
      st.src_req[cees_pkg::SRC_INVALID] = flags_q[cees_pkg::BIT_INVALID]
                                          & ena_q[cees_pkg::BIT_INVALID];
      st.fifo_req = fifo_q & {16{ena_q[cees_pkg::BIT_RXBUF] | ena_q[cees_pkg::BIT_TXBUF]}};
      st.tx_cnt   = txcnt_q;
      st.rx_cnt   = rxcnt_q;
   end

   // captured status; filter, fifo and counts one cycle behind the inputs, code, error state and irq two
   always_comb begin
      code_d   = st.code;
      filt_d   = matched_filter_number;
      fifo_d   = fifo_int_pending;
      txcnt_d  = tx_error_count;
      rxcnt_d  = rx_error_count;
      estate_d = st.err_state;
      irq_d    = |(flags_q & ena_q);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_q   <= cees_pkg::CODE_NONE;
         filt_q   <= cees_pkg::FILT_RESET;
         fifo_q   <= 16'h0000;
         txcnt_q  <= 9'h000;
         rxcnt_q  <= 8'h00;
         estate_q <= 6'h00;
         irq_q    <= 1'b0;
      end else begin
         code_q   <= code_d;
         filt_q   <= filt_d;
         fifo_q   <= fifo_d;
         txcnt_q  <= txcnt_d;
         rxcnt_q  <= rxcnt_d;
         estate_q <= estate_d;
         irq_q    <= irq_d;
      end
   end
endmodule : cees_status_top

// [verif/cees_status_sva.sv]
// assertion checker watching the status block ports
`timescale 1ns/1ns
module cees_status_sva (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [4:0]  matched_filter_number,
   input wire logic [15:0] fifo_int_pending,
   input wire logic [8:0]  tx_error_count,
   input wire logic [7:0]  rx_error_count
);
   logic [37:0] in_d;
   logic [37:0] in_q;
   logic [1:0]  st_d;
   logic [1:0]  st_q;
   logic        rd;
   logic        re;
   logic        rc;
   logic        rf;
   // judge reads only once inputs settled, state lags the counts
   always_comb begin
      in_d = {tx_error_count, rx_error_count, matched_filter_number, fifo_int_pending};
      st_d = (in_q != in_d) ? 2'h0 : st_q + {1'b0, st_q != 2'h3};
      rd = pready && !pwrite && !pslverr && st_q[1];
      re = rd && paddr == cees_pkg::ADDR_ERR;
      rc = rd && paddr == cees_pkg::ADDR_CODE;
      rf = rd && paddr == cees_pkg::ADDR_FIFO;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= 2'h0;
         in_q <= '0;
      end else begin
         st_q <= st_d;
         in_q <= in_d;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_BUSOFF:
      assert property (re |-> prdata[21] == tx_error_count[8]) else $error("bus-off bit wrong");
   AST_TXPAS:
      assert property (re |-> prdata[20] == (tx_error_count >= 9'h080)) else $error("tx passive");
   AST_RXPAS:
      assert property (re |-> prdata[19] == rx_error_count[7]) else $error("rx passive wrong");
   AST_TX_WARNING_STATE:
      assert property (re |-> prdata[18] == (tx_error_count >= 9'h060 && tx_error_count < 9'h080))
         else $error("tx warning wrong");
   AST_RX_WARNING_STATE:
      assert property (re |-> prdata[17] == (rx_error_count[7:5] == 3'h3)) else $error("rx warn");
   AST_ANYWARN:
      assert property (re |-> prdata[16] == (prdata[18] | prdata[17])) else $error("any warning");
   AST_COUNTS:
      assert property (re |-> prdata[15:0] == {tx_error_count[7:0], rx_error_count})
         else $error("error counts wrong");
   AST_FILT:
      assert property (rc |-> prdata[12:8] == matched_filter_number && prdata[31:13] == 19'h0)
         else $error("filter number wrong");
   AST_CODE:
      assert property (rc |-> prdata[7:0] <= 8'h0F || prdata[7:0] inside {[8'h40:8'h48]})
         else $error("reserved code seen");
   AST_FIFO:
      assert property (rf |-> prdata == {16'h0000, fifo_int_pending}) else $error("fifo pending");
   AST_UNMAP:
      assert property (pready && pslverr |-> prdata == 32'h0 ##1 !pready) else $error("unmapped");
endmodule : cees_status_sva
bind cees_status_top cees_status_sva i_sva (.*);

// [verif/cees_can_side.sv]
// can side stand-in: event strobes, error counts, fifo and filter levels
`timescale 1ns/1ns
module cees_can_side (
   input  wire logic        pclk,
   output      logic [6:0]  ev,
   output      logic [8:0]  tec,
   output      logic [7:0]  rec,
   output      logic [15:0] fifo,
   output      logic [4:0]  filt
);
   initial begin
      ev = 7'h00;
      tec = 9'h000;
      rec = 8'h00;
      fifo = 16'h0000;
      filt = 5'h00;
   end
   // one-cycle strobes, called just after an edge
   task automatic pulse(input logic [6:0] m);
      ev <= m;
      @(posedge pclk);
      ev <= 7'h00;
   endtask : pulse
   task automatic levels(input logic [8:0] t, input logic [7:0] r, input logic [15:0] f,
                         input logic [4:0] h);
      tec <= t;
      rec <= r;
      fifo <= f;
      filt <= h;
   endtask : levels
endmodule : cees_can_side

// [verif/test_can_event_and_error_status.sv]
// self-checking bench for the can event and error status block
`timescale 1ns/1ns
module test_can_event_and_error_status;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, module_on, irq_request, err;
   logic        rxb = 1'b0;
   logic        txb = 1'b0;
   // both start equal and nonzero: a false mode edge after reset would show
   logic [2:0]  cur = 3'h4;
   logic [2:0]  req = 3'h4;
   logic [6:0]  ev;
   logic [8:0]  tec;
   logic [7:0]  rec;
   logic [15:0] fifo;
   logic [4:0]  filt;
   int          n_errors = 0;
   int          n_compared = 0;
   int          fl = 0;
   int          en = 0;
   int          on = 0;
   int          i, k;
   int          fb[8] = '{13, 14, 11, 12, 12, 2, 3, 15};
   int          tv[8] = '{95, 96, 127, 128, 255, 256, 511, 0};
   always #50 pclk = ~pclk;
   cees_can_side i_can (.pclk(pclk), .ev(ev), .tec(tec), .rec(rec), .fifo(fifo), .filt(filt));
   cees_status_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wake_event(ev[1]), .bus_error_event(ev[0]), .sys_addr_error(ev[3]),
      .sys_bw_error(ev[4]), .rx_overflow_event(ev[2]), .timer_overflow_event(ev[5]),
      .invalid_message_event(ev[6]), .rx_buffer_pending(rxb), .tx_buffer_pending(txb),
      .current_operating_mode(cur), .requested_operating_mode(req),
      .matched_filter_number(filt), .fifo_int_pending(fifo), .tx_error_count(tec),
      .rx_error_count(rec), .module_on(module_on), .irq_request(irq_request));
   task automatic test_done;
      if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // holds the request until pready, releases after, then idles one edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 16);
      if (t >= 16) begin
         n_errors++;
         test_done;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      if (a == 8'h00) begin
         en = d[31:16] & 16'hF80F;
         fl = fl & ~(~d[15:0] & 16'hE80C);
      end
      if (a == 8'h10) begin
         if (d[15] && on == 0) fl = fl & ~32'h1000;
         on = d[15];
      end
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rchk
   task automatic fire(input int s);
      if (s == 6) begin
         req <= 3'h0;
         @(posedge pclk);
         cur <= 3'h0;
         @(posedge pclk);
      end else i_can.pulse(7'(1 << (s == 7 ? 6 : s)));
   endtask : fire
   function automatic int ef(int t, int r);
      int tw = (t >= 96 && t < 128) ? 1 : 0;
      int rw = (r >= 96 && r < 128) ? 1 : 0;
      return (t >= 256 ? 1 << 21 : 0) | (t >= 128 ? 1 << 20 : 0) | (r >= 128 ? 1 << 19 : 0)
         | (tw << 18) | (rw << 17) | ((tw | rw) << 16) | ((t & 255) << 8) | r;
   endfunction : ef
   function automatic int fcode(int f);
      for (int j = 0; j < 16; j++) if (f[j]) return j;
      return 32'h40;
   endfunction : fcode
   initial begin
      void'($urandom(28971));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 5; i++) rchk(8'(i * 4), i == 1 ? 32'h40 : 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      wr(8'h10, 32'h8000);
      chk({31'h0, module_on}, 32'h1);
      for (i = 0; i < 8; i++) begin
         wr(8'h00, 32'h0);
         fire(i);
         repeat (3) @(posedge pclk);
         fl = fl | (1 << fb[i]);
         rchk(8'h00, (en << 16) | fl);
         rchk(8'h04, 32'h40);
         chk({31'h0, irq_request}, 32'h0);
         wr(8'h00, (1 << (fb[i] + 16)) | 32'hFFFF);
         repeat (2) @(posedge pclk);
         chk({31'h0, irq_request}, 32'h1);
         rchk(8'h04, 32'h41 + i);
      end
      wr(8'h00, 32'h0);
      rchk(8'h00, fl);
      wr(8'h10, 32'h0);
      wr(8'h10, 32'h8000);
      rchk(8'h00, fl);
      wr(8'h00, 32'hFFFFFFFF);
      i_can.pulse(7'h22);
      repeat (3) @(posedge pclk);
      rchk(8'h00, 32'hF80F4004);
      rchk(8'h04, 32'h42);
      wr(8'h00, 32'hF80FBFFF);
      rchk(8'h04, 32'h46);
      wr(8'h00, 32'hF80F0000);
      rchk(8'h04, 32'h40);
      for (i = 0; i < 5; i++) begin
         k = $urandom;
         if (i == 0) k = k & ~32'hFFFF;
         rxb <= k[17];
         txb <= k[16];
         i_can.levels(tec, rec, 16'(k), 5'(k >> 20));
         repeat (4) @(posedge pclk);
         rchk(8'h00, 32'hF80F0000 | ((k >> 16) & 3));
         rchk(8'h0C, k & 32'hFFFF);
         rchk(8'h04, (((k >> 20) & 31) << 8) | fcode(k & 32'hFFFF));
      end
      for (i = 0; i < 8; i++) begin
         i_can.levels(9'(tv[i]), 8'(tv[7 - i]), 16'h0, 5'h0);
         repeat (4) @(posedge pclk);
         rchk(8'h08, ef(tv[i], tv[7 - i] & 255));
      end
      wr(8'h08, 32'hFFFFFFFF);
      wr(8'h0C, 32'hFFFFFFFF);
      rchk(8'h08, ef(0, 95));
      rchk(8'h10, 32'h8000);
      test_done;
   end
endmodule : test_can_event_and_error_status
